//--- hw/lcbd_defs.vh
`ifndef LCBD_DEFS_VH
`define LCBD_DEFS_VH

// register indices; byte address is four times the index
`define LCBD_IDX_CTRL1   10'h04f
`define LCBD_IDX_PHASE1  10'h050
`define LCBD_IDX_PHASE2  10'h051
`define LCBD_IDX_PHASE3  10'h052
`define LCBD_IDX_PHASE4  10'h053
`define LCBD_IDX_PAUSE   10'h054
`define LCBD_IDX_DUTY    10'h055
`define LCBD_IDX_ONTIME  10'h056
`define LCBD_IDX_STATUS  10'h060

// field layout
`define LCBD_CUR_MSB     3
`define LCBD_RAMP_BIT    5
`define LCBD_LEN_MSB     6
`define LCBD_CODE_MSB    4

// reset values
`define LCBD_RST_BYTE    8'h00

// timing
`define LCBD_CLK_HZ      10000000
`define LCBD_SLOT_US     250
`define LCBD_UNIT_MS     64
`define LCBD_PERIOD_MS   8
`define LCBD_SLOT_CYC    (`LCBD_CLK_HZ / 1000000 * `LCBD_SLOT_US)
`define LCBD_UNIT_SLOTS  (`LCBD_UNIT_MS * 1000 / `LCBD_SLOT_US)
`define LCBD_PER_SLOTS   (`LCBD_PERIOD_MS * 1000 / `LCBD_SLOT_US)

`endif

//--- hw/lcbd_tick.v
`timescale 1ns/1ps
`default_nettype none
`include "lcbd_defs.vh"

module lcbd_tick #(
  parameter SLOT_CYC = `LCBD_SLOT_CYC
) (
  // clock and reset
  input  wire       ref_clk_i,
  input  wire       arst_n_i,
  // slot timing
  output reg        slot_tick_o,
  output reg  [7:0] slot_idx_o,
  output reg        unit_tick_o
);

  localparam [31:0] CYC_W     = SLOT_CYC - 1;
  localparam [31:0] SLOT_W    = `LCBD_UNIT_SLOTS - 1;
  localparam [15:0] LAST_CYC  = CYC_W[15:0];
  localparam [7:0]  LAST_SLOT = SLOT_W[7:0];

  reg [15:0] cyc_q;

  // 250 us slot enable, 256 slots make one 64 ms unit
  always @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      cyc_q       <= 16'h0000;
      slot_tick_o <= 1'b0;
      slot_idx_o  <= 8'h00;
      unit_tick_o <= 1'b0;
    end
    else
    begin
      slot_tick_o <= 1'b0;
      unit_tick_o <= 1'b0;
      if (cyc_q == LAST_CYC)
      begin
        cyc_q       <= 16'h0000;
        slot_tick_o <= 1'b1;
        slot_idx_o  <= slot_idx_o + 8'h01;
        unit_tick_o <= (slot_idx_o == LAST_SLOT);
      end
      else
      begin
        cyc_q <= cyc_q + 16'h0001;
      end
    end
  end

endmodule
`default_nettype wire

//--- hw/lcbd_pwm.v
`timescale 1ns/1ps
`default_nettype none
`include "lcbd_defs.vh"

module lcbd_pwm (
  // clock and reset
  input  wire       ref_clk_i,
  input  wire       arst_n_i,
  // timing and setting
  input  wire [4:0] slot_i,
  input  wire [4:0] duty_i,
  // dimming level
  output reg        pwm_o
);

  // high while slot index within the 8 ms period is at or below the code
  always @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      pwm_o <= 1'b0;
    else
      pwm_o <= (slot_i <= duty_i);
  end

endmodule
`default_nettype wire

//--- hw/lcbd_top.v
// The APB register port was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "lcbd_defs.vh"

// Notes on behaviour
// R01: ctrl1 bits 3..0 hold the sink current select, reset to zero
// R02: phase one lasts its 7-bit value times 64 ms; zero skips it
// R03: phase two lasts its 7-bit value times 64 ms
// R04: phase three lasts its 7-bit value times 64 ms, reset zero
// R05: phase four lasts its 7-bit value times 64 ms
// R06: pause lasts its 7-bit value times 64 ms, up to 127 units
// R07: dimming repeats every 8 ms, high for (code+1)/32 of it
// R08: dimming code all ones keeps the on signal steadily high
// R09: all control registers clear to zero on power-on reset
// R10: reserved bits ignore writes and read back as zero
// R11: ctrl1 bit 5 enables brightness ramping, off after reset
// R12: on-time is a 5-bit value times 64 ms, at most 31
module lcbd_top #(
  parameter SLOT_CYC = `LCBD_SLOT_CYC
) (
  // clock and reset
  input  wire        ref_clk_i,
  input  wire        arst_n_i,
  // apb slave
  input  wire        psel_i,
  input  wire        penable_i,
  input  wire        pwrite_i,
  input  wire [11:0] paddr_i,
  input  wire [31:0] pwdata_i,
  input  wire [3:0]  pstrb_i,
  output reg  [31:0] prdata_o,
  output reg         pready_o,
  output reg         pslverr_o,
  // led sink control
  output reg         channel_on_signal_o,
  output reg  [3:0]  sink_current_select_o
);

  localparam [2:0] ST_P1    = 3'h0;
  localparam [2:0] ST_P2    = 3'h1;
  localparam [2:0] ST_P3    = 3'h2;
  localparam [2:0] ST_P4    = 3'h3;
  localparam [2:0] ST_PAUSE = 3'h4;
  localparam [2:0] ST_FIX   = 3'h5;

  localparam [31:0] UNIT_W     = `LCBD_UNIT_SLOTS;
  localparam [31:0] PER_W      = `LCBD_PER_SLOTS - 1;
  localparam [14:0] UNIT_SLOTS = UNIT_W[14:0];
  localparam [4:0]  PER_LAST   = PER_W[4:0];

  // register file
  reg [3:0] cur_q;
  reg       ramp_q;
  reg [6:0] len1_q;
  reg [6:0] len2_q;
  reg [6:0] len3_q;
  reg [6:0] len4_q;
  reg [6:0] lenp_q;
  reg [4:0] duty_q;
  reg [4:0] ontime_q;

  // sequencer state
  reg [2:0]  state_q;
  reg [2:0]  state_d;
  reg [14:0] cnt_q;
  reg [4:0]  on_units_q;
  reg [4:0]  ramp_lvl_q;
  reg        lit;
  reg        expired;
  reg [6:0]  cur_len;
  reg        all_zero;

  // bus decode
  wire [9:0] idx;
  wire       wr_en;
  reg        hit;
  reg [7:0]  rd_byte;
  wire       setup;

  // timing
  wire       slot_tick;
  wire [7:0] slot_idx;
  wire       unit_tick;
  wire [4:0] eff_duty;
  wire       pwm;

  function [14:0] phase_last;
    input [6:0] len;
    reg   [14:0] prod;
    begin
      prod       = {8'h00, len} * UNIT_SLOTS;
      phase_last = prod - 15'h0001;
    end
  endfunction

  function is_lit;
    input [2:0] st;
    begin
      is_lit = (st == ST_P1) || (st == ST_P3) || (st == ST_FIX);
    end
  endfunction

  assign idx   = paddr_i[11:2];
  assign setup = psel_i && !penable_i && !pready_o;
  assign wr_en = psel_i && penable_i && pready_o && pwrite_i && hit
                 && pstrb_i[0];

  lcbd_tick #(
    .SLOT_CYC (SLOT_CYC)
  ) u_tick (
    .ref_clk_i   (ref_clk_i),
    .arst_n_i    (arst_n_i),
    .slot_tick_o (slot_tick),
    .slot_idx_o  (slot_idx),
    .unit_tick_o (unit_tick)
  );

  // ramped level replaces the code while ramping is on
  assign eff_duty = ramp_q ? ramp_lvl_q : duty_q;

  lcbd_pwm u_pwm (
    .ref_clk_i (ref_clk_i),
    .arst_n_i  (arst_n_i),
    .slot_i    (slot_idx[4:0]),
    .duty_i    (eff_duty),
    .pwm_o     (pwm)
  );

  // read mux and address hit
  always @*
  begin
    hit     = 1'b1;
    rd_byte = `LCBD_RST_BYTE;
    case (idx)
      // R10: reserved bits zero
      `LCBD_IDX_CTRL1:
        rd_byte = {2'b00, ramp_q, 1'b0, cur_q};
      `LCBD_IDX_PHASE1:
        rd_byte = {1'b0, len1_q};
      `LCBD_IDX_PHASE2:
        rd_byte = {1'b0, len2_q};
      `LCBD_IDX_PHASE3:
        rd_byte = {1'b0, len3_q};
      `LCBD_IDX_PHASE4:
        rd_byte = {1'b0, len4_q};
      `LCBD_IDX_PAUSE:
        rd_byte = {1'b0, lenp_q};
      `LCBD_IDX_DUTY:
        rd_byte = {3'b000, duty_q};
      `LCBD_IDX_ONTIME:
        rd_byte = {3'b000, ontime_q};
      `LCBD_IDX_STATUS:
        rd_byte = {2'b00, expired, channel_on_signal_o, lit, state_q};
      default:
        hit = 1'b0;
    endcase
  end

  // apb answer: one wait-free access phase, data fixed at setup
  always @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      pready_o  <= 1'b0;
      prdata_o  <= 32'h00000000;
      pslverr_o <= 1'b0;
    end
    else
    begin
      pready_o <= setup;
      if (setup)
      begin
        prdata_o  <= pwrite_i ? 32'h00000000 : {24'h000000, rd_byte};
        pslverr_o <= !hit || (pwrite_i && idx == `LCBD_IDX_STATUS);
      end
      else if (!psel_i)
      begin
        pslverr_o <= 1'b0;
      end
    end
  end

  // register writes
  always @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      // R09: zero on power-on reset
      cur_q    <= 4'h0;
      ramp_q   <= 1'b0;
      len1_q   <= 7'h00;
      len2_q   <= 7'h00;
      len3_q   <= 7'h00;
      len4_q   <= 7'h00;
      lenp_q   <= 7'h00;
      duty_q   <= 5'h00;
      ontime_q <= 5'h00;
    end
    else if (wr_en)
    begin
      case (idx)
        `LCBD_IDX_CTRL1:
        begin
          // R01: current select field
          cur_q  <= pwdata_i[`LCBD_CUR_MSB:0];
          // R11: ramp enable bit
          ramp_q <= pwdata_i[`LCBD_RAMP_BIT];
        end
        // R02: phase one length
        `LCBD_IDX_PHASE1:
          len1_q <= pwdata_i[`LCBD_LEN_MSB:0];
        // R03: phase two length
        `LCBD_IDX_PHASE2:
          len2_q <= pwdata_i[`LCBD_LEN_MSB:0];
        // R04: phase three length
        `LCBD_IDX_PHASE3:
          len3_q <= pwdata_i[`LCBD_LEN_MSB:0];
        // R05: phase four length
        `LCBD_IDX_PHASE4:
          len4_q <= pwdata_i[`LCBD_LEN_MSB:0];
        // R06: pause length
        `LCBD_IDX_PAUSE:
          lenp_q <= pwdata_i[`LCBD_LEN_MSB:0];
        // R07: dimming code
        `LCBD_IDX_DUTY:
          duty_q <= pwdata_i[`LCBD_CODE_MSB:0];
        // R12: on-time code
        `LCBD_IDX_ONTIME:
          ontime_q <= pwdata_i[`LCBD_CODE_MSB:0];
        default:
          cur_q <= cur_q;
      endcase
    end
  end

  // phase selection
  always @*
  begin
    all_zero = (len1_q == 7'h00) && (len2_q == 7'h00) &&
               (len3_q == 7'h00) && (len4_q == 7'h00) &&
               (lenp_q == 7'h00);
    lit      = is_lit(state_q);
    expired  = (ontime_q != 5'h00) && (on_units_q == ontime_q);
    case (state_q)
      ST_P1:
        cur_len = len1_q;
      ST_P2:
        cur_len = len2_q;
      ST_P3:
        cur_len = len3_q;
      ST_P4:
        cur_len = len4_q;
      ST_PAUSE:
        cur_len = lenp_q;
      default:
        cur_len = 7'h00;
    endcase
  end

  // next phase: zero length moves on at once, else after len x 64 ms
  always @*
  begin
    state_d = state_q;
    case (state_q)
      ST_FIX:
        if (!all_zero)
          state_d = ST_P1;
      ST_P1, ST_P2, ST_P3, ST_P4, ST_PAUSE:
        if (all_zero)
          state_d = ST_FIX;
        else if (cur_len == 7'h00 ||
                 (slot_tick && cnt_q == phase_last(cur_len)))
          state_d = (state_q == ST_PAUSE) ? ST_P1 : state_q + 3'h1;
      default:
        state_d = ST_FIX;
    endcase
  end

  // sequencer
  always @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      state_q <= ST_FIX;
      cnt_q   <= 15'h0000;
    end
    else
    begin
      state_q <= state_d;
      // R02: phase timer in 250 us slots
      if (state_d != state_q)
        cnt_q <= 15'h0000;
      else if (slot_tick)
        cnt_q <= cnt_q + 15'h0001;
    end
  end

  // on-time limit, restarted by any write of the on-time register
  always @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      on_units_q <= 5'h00;
    end
    // R12: count 64 ms units
    else if (wr_en && idx == `LCBD_IDX_ONTIME)
    begin
      on_units_q <= 5'h00;
    end
    else if (unit_tick && !expired && ontime_q != 5'h00)
    begin
      on_units_q <= on_units_q + 5'h01;
    end
  end

  // brightness ramp, one step per 8 ms period while lit
  always @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      ramp_lvl_q <= 5'h00;
    end
    // R11: ramp towards the code
    else if (!lit)
    begin
      ramp_lvl_q <= 5'h00;
    end
    else if (ramp_lvl_q > duty_q)
    begin
      ramp_lvl_q <= duty_q;
    end
    else if (slot_tick && slot_idx[4:0] == PER_LAST &&
             ramp_lvl_q < duty_q)
    begin
      ramp_lvl_q <= ramp_lvl_q + 5'h01;
    end
  end

  // sink outputs
  always @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      channel_on_signal_o   <= 1'b0;
      sink_current_select_o <= 4'h0;
    end
    else
    begin
      // R07: dimmed while lit
      // R08: full code keeps the level high
      channel_on_signal_o   <= lit && !expired &&
                               (pwm || eff_duty == PER_LAST);
      // R01: current select to sink
      sink_current_select_o <= cur_q;
    end
  end

endmodule
`default_nettype wire

//--- bench/lcbd_monitor.sv
`timescale 1ns/1ps
`default_nettype none
`include "lcbd_defs.vh"
module lcbd_chk (
  // clock and reset
  input wire logic        ref_clk_i,
  input wire logic        arst_n_i,
  // apb slave
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0]  pstrb_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  // led sink control
  input wire logic        channel_on_signal_o,
  input wire logic [3:0]  sink_current_select_o
);
  wire logic [9:0] idx = paddr_i[11:2];
  wire logic       map = (idx >= `LCBD_IDX_CTRL1 && idx <= `LCBD_IDX_ONTIME)
                         || idx == `LCBD_IDX_STATUS;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!arst_n_i);
  sequence s_setup;
    psel_i && !penable_i;
  endsequence
  sequence s_ack;
    pready_o && psel_i && penable_i;
  endsequence
  property p_ack_next;
    s_setup |=> s_ack;
  endproperty
  property p_ack_one;
    pready_o |=> !pready_o;
  endproperty
  property p_ack_access;
    pready_o |-> psel_i && penable_i;
  endproperty
  property p_err_unmap;
    s_setup ##0 !map |=> s_ack ##0 pslverr_o;
  endproperty
  property p_ok_read;
    s_setup ##0 (map && !pwrite_i) |=> !pslverr_o;
  endproperty
  property p_upper;
    s_ack |-> prdata_o[31:8] == 24'h0;
  endproperty
  property p_rsvd_ctrl;
    s_ack ##0 (!pwrite_i && idx == `LCBD_IDX_CTRL1)
      |-> prdata_o[7:6] == 2'b00 && !prdata_o[4];
  endproperty
  property p_rsvd_len;
    s_ack ##0 (!pwrite_i && idx >= `LCBD_IDX_PHASE1 && idx <= `LCBD_IDX_PAUSE)
      |-> !prdata_o[7];
  endproperty
  property p_cur;
    s_ack ##0 (pwrite_i && pstrb_i[0] && idx == `LCBD_IDX_CTRL1)
      |-> ##2 sink_current_select_o == $past(pwdata_i[3:0], 2);
  endproperty
  a_ack_next: assert property (p_ack_next)
    else $error("no ack after setup");
  a_ack_one: assert property (p_ack_one)
    else $error("ack longer than one cycle");
  a_ack_access: assert property (p_ack_access)
    else $error("ack outside access phase");
  a_err_unmap: assert property (p_err_unmap)
    else $error("unmapped access not refused");
  a_ok_read: assert property (p_ok_read)
    else $error("mapped read refused");
  a_upper: assert property (p_upper)
    else $error("upper read data not zero");
  a_rsvd_ctrl: assert property (p_rsvd_ctrl)
    else $error("ctrl1 reserved bits set");
  a_rsvd_len: assert property (p_rsvd_len)
    else $error("length reserved bit set");
  a_cur: assert property (p_cur)
    else $error("current select not updated");
endmodule
`default_nettype wire

//--- bench/lcbd_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "lcbd_defs.vh"
module tb;
  logic        ref_clk_i = 1'b0;
  logic        arst_n_i  = 1'b0;
  logic        psel_i    = 1'b0;
  logic        penable_i = 1'b0;
  logic        pwrite_i  = 1'b0;
  logic [11:0] paddr_i   = 12'h000;
  logic [31:0] pwdata_i  = 32'h0;
  logic [3:0]  pstrb_i   = 4'hf;
  logic [31:0] prdata_o;
  logic        pready_o;
  logic        pslverr_o;
  logic        channel_on_signal_o;
  logic [3:0]  sink_current_select_o;
  logic [31:0] rdv;
  logic        erv;
  int          hi;
  int          err_total = 0;
  int          cmp_count = 0;
  logic [9:0]  idx_t [8] = '{`LCBD_IDX_CTRL1, `LCBD_IDX_PHASE1,
    `LCBD_IDX_PHASE2, `LCBD_IDX_PHASE3, `LCBD_IDX_PHASE4,
    `LCBD_IDX_PAUSE, `LCBD_IDX_DUTY, `LCBD_IDX_ONTIME};
  logic [7:0]  msk_t [8] = '{8'h2f, 8'h7f, 8'h7f, 8'h7f, 8'h7f, 8'h7f,
    8'h1f, 8'h1f};
  logic [7:0]  duty_t [3] = '{8'h00, 8'h07, 8'h1f};
  always #50 ref_clk_i = ~ref_clk_i;
  // short slot keeps 64 ms units to 1024 cycles
  lcbd_top #(.SLOT_CYC(4)) u_lcbd_top (.ref_clk_i, .arst_n_i, .psel_i,
    .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .pstrb_i, .prdata_o,
    .pready_o, .pslverr_o, .channel_on_signal_o, .sink_current_select_o);
  task complete_run;
    $display("checks %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      err_total++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask
  task apb(input logic w, input logic [9:0] i, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge ref_clk_i);
    psel_i    <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i  <= w;
    paddr_i   <= {i, 2'b00};
    pwdata_i  <= {24'h0, d};
    @(posedge ref_clk_i);
    penable_i <= 1'b1;
    @(posedge ref_clk_i);
    while (pready_o !== 1'b1 && n < 16)
    begin
      n++;
      @(posedge ref_clk_i);
    end
    chk("pready", 1, pready_o);
    rdv = prdata_o;
    erv = pslverr_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task rd(input logic [9:0] i, input logic [7:0] e);
    apb(1'b0, i, 8'h00);
    chk("rdata", {24'h0, e}, rdv);
    chk("slverr", 0, erv);
  endtask
  task high(input int n);
    hi = 0;
    repeat (n)
    begin
      @(negedge ref_clk_i);
      if (channel_on_signal_o === 1'b1)
        hi++;
    end
  endtask
  task t_regs;
    for (int k = 0; k < 8; k++)
      rd(idx_t[k], 8'h00);
    chk("cur", 0, sink_current_select_o);
    for (int k = 0; k < 8; k++)
    begin
      apb(1'b1, idx_t[k], 8'hff);
      rd(idx_t[k], msk_t[k]);
    end
    chk("cur", 4'hf, sink_current_select_o);
    pstrb_i <= 4'h0;
    apb(1'b1, `LCBD_IDX_CTRL1, 8'h05);
    pstrb_i <= 4'hf;
    rd(`LCBD_IDX_CTRL1, 8'h2f);
    arst_n_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    arst_n_i <= 1'b1;
    for (int k = 0; k < 8; k++)
      rd(idx_t[k], 8'h00);
    chk("cur", 0, sink_current_select_o);
    for (int k = 0; k < 8; k++)
      apb(1'b1, idx_t[k], 8'h00);
    apb(1'b0, 10'h070, 8'h00);
    chk("unmap err", 1, erv);
    chk("unmap data", 0, rdv);
    apb(1'b1, `LCBD_IDX_STATUS, 8'hff);
    chk("status err", 1, erv);
  endtask
  task t_dim;
    for (int k = 0; k < 3; k++)
    begin
      apb(1'b1, `LCBD_IDX_DUTY, duty_t[k]);
      repeat (8) @(posedge ref_clk_i);
      high(512);
      chk("duty hi", 16 * (duty_t[k] + 1), hi);
    end
  endtask
  task t_blink;
    apb(1'b1, `LCBD_IDX_PHASE1, 8'h02);
    apb(1'b1, `LCBD_IDX_PHASE2, 8'h01);
    apb(1'b1, `LCBD_IDX_PHASE3, 8'h01);
    apb(1'b1, `LCBD_IDX_PHASE4, 8'h01);
    apb(1'b1, `LCBD_IDX_PAUSE, 8'h01);
    high(2048);
    high(6144);
    chk("blink lit", 1, hi >= 3040 && hi <= 3104);
    apb(1'b1, `LCBD_IDX_CTRL1, 8'h20);
    high(6144);
    chk("ramp lit", 1, hi >= 256 && hi <= 1280);
    apb(1'b1, `LCBD_IDX_CTRL1, 8'h00);
    for (int k = 1; k < 6; k++)
      apb(1'b1, idx_t[k], 8'h00);
  endtask
  task t_ontime;
    apb(1'b1, `LCBD_IDX_ONTIME, 8'h01);
    high(2100);
    high(512);
    chk("on expired", 0, hi);
    rd(`LCBD_IDX_STATUS, 8'h2d);
    apb(1'b1, `LCBD_IDX_ONTIME, 8'h00);
    repeat (8) @(posedge ref_clk_i);
    high(512);
    chk("on unlimited", 512, hi);
    rd(`LCBD_IDX_STATUS, 8'h1d);
  endtask
  initial
  begin
    repeat (40000) @(posedge ref_clk_i);
    err_total++;
    complete_run;
  end
  initial
  begin
    repeat (16) @(posedge ref_clk_i);
    arst_n_i <= 1'b1;
    t_regs;
    t_dim;
    t_blink;
    t_ontime;
    complete_run;
  end
endmodule
bind lcbd_top lcbd_chk u_lcbd_chk (.ref_clk_i, .arst_n_i, .psel_i,
  .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .pstrb_i, .prdata_o,
  .pready_o, .pslverr_o, .channel_on_signal_o, .sink_current_select_o);
`default_nettype wire
